// ==== rtl/flash_host_pkg.sv ====
/*
  Package for the flash erase/suspend host controller: command codes,
  unlock addresses, bus timing counts and carrier structs.
  Assumes a 100 MHz clock and a parallel NOR flash with 16-bit data.
*/
package flash_host_pkg;
  localparam int CLK_MHZ = 100;
  localparam int AW = 22;
  localparam int DW = 16;
  localparam logic [10:0] ADDR_UNLOCK1 = 11'h555;
  localparam logic [10:0] ADDR_UNLOCK2 = 11'h2aa;
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  // bus cycle phases in ns, converted to cycles (least times round up)
  localparam int T_SETUP_NS = 30;
  localparam int T_PULSE_NS = 40;
  localparam int T_HOLD_NS = 30;
  localparam int T_SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_PULSE_CYC = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int T_HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  // sector-erase window and suspend latencies
  localparam int WINDOW_US = 50;
  localparam int PROG_SUSP_US = 15;
  localparam int ERASE_SUSP_US = 20;
  // extra sectors must come well inside the window: longest time rounds down
  localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ;
  localparam int PROG_SUSP_CYC = PROG_SUSP_US * CLK_MHZ;
  localparam int ERASE_SUSP_CYC = ERASE_SUSP_US * CLK_MHZ;
  localparam int CW = 16;
  localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CW-1:0] CNT_ONE = 16'h0001;
  localparam int DATA_POLL = 7;
  localparam int TOGGLE = 6;
  localparam int ERASE_TIMER = 3;
  localparam int ALT_TOGGLE = 2;

  typedef enum logic [2:0] {
    OP_CHIP_ERASE = 3'h0,
    OP_SECTOR_ERASE = 3'h1,
    OP_ADD_SECTOR = 3'h2,
    OP_SUSPEND = 3'h3,
    OP_RESUME = 3'h4,
    OP_RESET = 3'h5
  } op_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
  } bus_word_t;

  typedef struct packed {
    logic data_poll_bit;
    logic toggle_bit;
    logic erase_timer_bit;
    logic alternate_toggle_bit;
  } flash_status_t;
endpackage

// ==== rtl/flash_bus_cycle.sv ====
/*
  One asynchronous flash bus cycle (write or read) with set-up, strobe
  and hold phases. Assumes a single clock; the data pins are two-way,
  split into input, output and output enable.
*/
`timescale 1ns/1ps
module flash_bus_cycle (
  input wire logic clk,
  input wire logic rst_b,
  // request
  input wire logic start,
  input wire logic write,
  input wire flash_host_pkg::bus_word_t word,
  output logic busy,
  output logic done,
  output logic [flash_host_pkg::DW-1:0] rdata,
  // pins
  output logic [flash_host_pkg::AW-1:0] addr,
  output logic [flash_host_pkg::DW-1:0] dq_out,
  output logic dq_oe,
  input wire logic [flash_host_pkg::DW-1:0] dq_in,
  output logic ce_b,
  output logic we_b,
  output logic oe_b
);
  typedef enum logic [3:0] {
    IDLE = 4'b0001, SETUP = 4'b0010, PULSE = 4'b0100, HOLD = 4'b1000
  } phase_t;
  phase_t ph, next_ph;
  logic [7:0] cnt, next_cnt;
  logic wr, next_wr;
  logic [flash_host_pkg::AW-1:0] next_addr;
  logic [flash_host_pkg::DW-1:0] next_dq_out, next_rdata;
  logic next_done;
  // three-stage sampler; stage one feeds only stage two
  logic [flash_host_pkg::DW-1:0] s1, s2, s3;

  always_comb begin
    next_ph = ph;
    next_cnt = cnt;
    next_wr = wr;
    next_addr = addr;
    next_dq_out = dq_out;
    next_rdata = rdata;
    next_done = 1'b0;
    unique case (ph)
      IDLE: if (start) begin
        next_ph = SETUP;
        next_wr = write;
        next_addr = word.addr;
        next_dq_out = word.data;
        next_cnt = 8'(flash_host_pkg::T_SETUP_CYC);
      end
      SETUP: if (cnt <= 8'h01) begin
        next_ph = PULSE;
        // reads wait three extra cycles for the sampler
        next_cnt = 8'(flash_host_pkg::T_PULSE_CYC + (wr ? 0 : 3));
      end else next_cnt = cnt - 8'h01;
      PULSE: if (cnt <= 8'h01) begin
        next_ph = HOLD;
        if (!wr && s2 == s3) next_rdata = s3;
        next_cnt = 8'(flash_host_pkg::T_HOLD_CYC);
      end else next_cnt = cnt - 8'h01;
      HOLD: if (cnt <= 8'h01) begin
        next_ph = IDLE;
        next_done = 1'b1;
      end else next_cnt = cnt - 8'h01;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ph <= IDLE;
      cnt <= 8'h00;
      wr <= 1'b0;
      addr <= '0;
      dq_out <= '0;
      rdata <= '0;
      done <= 1'b0;
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      ph <= next_ph;
      cnt <= next_cnt;
      wr <= next_wr;
      addr <= next_addr;
      dq_out <= next_dq_out;
      rdata <= next_rdata;
      done <= next_done;
      s1 <= dq_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign busy = (ph != IDLE);
  assign ce_b = (ph == IDLE);
  assign we_b = !(ph == PULSE && wr);
  assign oe_b = !(ph != IDLE && !wr);
  assign dq_oe = (ph != IDLE) && wr;
endmodule

// ==== rtl/flash_erase_host.sv ====
/*
  Host-side sequencer for a parallel NOR flash: issues chip erase,
  sector erase with extra sectors queued in the time-out window,
  erase suspend and resume, and polls status bits.
  Assumes the flash is the only bus client and user orders come one at
  a time, each taken while READY is high.
*/
// Notes on behaviour
// [RL1] program suspend halts within 15 us
// [RL2] suspend accepted at any address
// [RL3] suspended program allows reads elsewhere
// [RL4] no ID or query while programming
// [RL5] ID mode allowed inside program suspend
// [RL6] resumed program reports data-poll and toggle
// [RL7] host resumes; extra resumes ignored
// [RL8] chip erase is six ordered write cycles
// [RL9] device preprograms before erase itself
// [RL10] chip erase done returns array read
// [RL11] chip erase ignores commands; reset aborts
// [RL12] sector erase is six write cycles
// [RL13] 50 us window queues more sectors
// [RL14] extra sectors spaced under 50 us
// [RL15] other command in window aborts sequence
// [RL16] window from last strobe; timer bit
// [RL17] erasing accepts only erase suspend
// [RL18] erase suspend only in sector erase
// [RL19] erase suspend takes up to 20 us
// [RL20] suspended sectors read back status
// [RL21] suspended program returns to suspend-read
// [RL22] host resumes erase; repeats ignored
// [RL23] erase resume valid only when suspended
// [RL24] only low address and data decoded
`timescale 1ns/1ps
module flash_erase_host #(
  parameter int WINDOW_CYC = flash_host_pkg::WINDOW_CYC,
  parameter int ERASE_SUSP_CYC = flash_host_pkg::ERASE_SUSP_CYC,
  parameter int PROG_SUSP_CYC = flash_host_pkg::PROG_SUSP_CYC
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // user orders
  input wire logic CMD_VALID,
  input wire flash_host_pkg::op_t CMD_OP,
  input wire logic [flash_host_pkg::AW-1:0] CMD_ADDR,
  output logic READY,
  output logic OP_DONE,
  output logic ERASING,
  output logic SUSPENDED,
  output logic WINDOW_LATE,
  output flash_host_pkg::flash_status_t STATUS,
  // flash pins
  output logic [flash_host_pkg::AW-1:0] FLASH_ADDR,
  output logic [flash_host_pkg::DW-1:0] FLASH_DQ_OUT,
  output logic FLASH_DQ_OE,
  input wire logic [flash_host_pkg::DW-1:0] FLASH_DQ_IN,
  output logic FLASH_CE_B,
  output logic FLASH_WE_B,
  output logic FLASH_OE_B,
  output logic FLASH_RESET_B
);
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_SEQ = 7'b0000010,
    S_WINDOW = 7'b0000100,
    S_POLL = 7'b0001000,
    S_WAIT = 7'b0010000,
    S_SUSP = 7'b0100000,
    S_RST = 7'b1000000
  } st_t;
  st_t st, next_st;
  logic [2:0] idx, next_idx, last, next_last;
  logic chip, next_chip, erasing, next_erasing, susp, next_susp;
  logic late, next_late, op_done, next_op_done, rst_pin, next_rst_pin;
  logic [flash_host_pkg::AW-1:0] sa, next_sa;
  logic [flash_host_pkg::CW-1:0] wcnt, next_wcnt, dly, next_dly;
  flash_host_pkg::flash_status_t stat, next_stat;
  logic bc_start, bc_write, bc_busy, bc_done;
  flash_host_pkg::bus_word_t bc_word;
  logic [flash_host_pkg::DW-1:0] bc_rdata;
  localparam logic [15:0] CNT_ZERO_L = flash_host_pkg::CNT_ZERO;
  localparam logic [15:0] CNT_ONE_L = flash_host_pkg::CNT_ONE;

  flash_bus_cycle u_cycle (
    .clk(CLOCK), .rst_b(RST_B),
    .start(bc_start), .write(bc_write), .word(bc_word),
    .busy(bc_busy), .done(bc_done), .rdata(bc_rdata),
    .addr(FLASH_ADDR), .dq_out(FLASH_DQ_OUT), .dq_oe(FLASH_DQ_OE),
    .dq_in(FLASH_DQ_IN), .ce_b(FLASH_CE_B), .we_b(FLASH_WE_B),
    .oe_b(FLASH_OE_B)
  );

  // six-cycle erase word; upper address/data left zero as don't care, except the full sector address in the sector cycle
  function automatic flash_host_pkg::bus_word_t seq_word(
    input logic [2:0] i, input logic c, input logic [21:0] a);
    flash_host_pkg::bus_word_t w;
    w = '0;
    unique case (i)
      3'h0, 3'h3: begin
        w.addr[10:0] = flash_host_pkg::ADDR_UNLOCK1;
        w.data[7:0] = flash_host_pkg::CMD_UNLOCK1;
      end
      3'h1, 3'h4: begin
        w.addr[10:0] = flash_host_pkg::ADDR_UNLOCK2;
        w.data[7:0] = flash_host_pkg::CMD_UNLOCK2;
      end
      3'h2: begin
        w.addr[10:0] = flash_host_pkg::ADDR_UNLOCK1;
        w.data[7:0] = flash_host_pkg::CMD_ERASE_SETUP;
      end
      default: begin
        w.addr = c ? {11'h000, flash_host_pkg::ADDR_UNLOCK1} : a;
        w.data[7:0] = c ? flash_host_pkg::CMD_CHIP_ERASE :
                          flash_host_pkg::CMD_SECTOR_ERASE;
      end
    endcase
    return w;
  endfunction // RL24

  always_comb begin
    next_st = st;
    next_idx = idx;
    next_last = last;
    next_chip = chip;
    next_erasing = erasing;
    next_susp = susp;
    next_late = late;
    next_op_done = 1'b0;
    next_rst_pin = 1'b1;
    next_sa = sa;
    next_wcnt = (wcnt != CNT_ZERO_L) ? wcnt - 16'h0001 : wcnt;
    next_dly = dly;
    next_stat = stat;
    bc_start = 1'b0;
    bc_write = 1'b1;
    bc_word = '0;
    unique case (st)
      S_IDLE: if (CMD_VALID) begin
        unique case (CMD_OP)
          flash_host_pkg::OP_CHIP_ERASE,
          flash_host_pkg::OP_SECTOR_ERASE: if (!erasing) begin
            next_chip = (CMD_OP == flash_host_pkg::OP_CHIP_ERASE); // RL8
            next_sa = CMD_ADDR; // RL12
            next_idx = 3'h0;
            next_last = 3'h5;
            next_erasing = 1'b1;
            next_late = 1'b0;
            next_st = S_SEQ;
          end
          flash_host_pkg::OP_SUSPEND: if (erasing && !chip && !susp) begin
            bc_start = 1'b1; // RL18
            bc_word.data[7:0] = flash_host_pkg::CMD_SUSPEND; // RL2
            next_dly = 16'(ERASE_SUSP_CYC); // RL19
            next_st = S_WAIT;
          end
          flash_host_pkg::OP_RESUME: if (susp) begin
            bc_start = 1'b1; // RL23
            bc_word.data[7:0] = flash_host_pkg::CMD_RESUME; // RL7
            next_susp = 1'b0; // RL22
            next_st = S_POLL;
          end
          flash_host_pkg::OP_RESET: begin
            next_rst_pin = 1'b0; // RL11
            next_dly = 16'(flash_host_pkg::T_PULSE_CYC * 10);
            next_st = S_RST;
          end
          default: ;
        endcase
      end
      S_SEQ: if (!bc_busy) begin
        bc_start = 1'b1;
        bc_word = seq_word(idx, chip, sa);
        if (idx == last) begin
          next_wcnt = 16'(WINDOW_CYC); // RL16
          next_st = chip ? S_POLL : S_WINDOW;
        end else next_idx = idx + 3'h1;
      end
      S_WINDOW: if (!bc_busy) begin
        if (CMD_VALID && CMD_OP == flash_host_pkg::OP_ADD_SECTOR) begin
          if (wcnt == CNT_ZERO_L) next_late = 1'b1; // RL14
          bc_start = 1'b1;
          bc_word.addr = CMD_ADDR; // RL13
          bc_word.data[7:0] = flash_host_pkg::CMD_SECTOR_ERASE;
          next_wcnt = 16'(WINDOW_CYC);
        end else if (CMD_VALID && CMD_OP == flash_host_pkg::OP_SUSPEND) begin
          bc_start = 1'b1; // RL19
          bc_word.data[7:0] = flash_host_pkg::CMD_SUSPEND;
          // two counts: route via the suspend wait, not a status poll
          next_dly = CNT_ONE_L + CNT_ONE_L;
          next_st = S_WAIT;
        end else if (CMD_VALID) begin
          // the flash must see the foreign command to drop its window
          bc_start = 1'b1; // RL15
          bc_word.data[7:0] = flash_host_pkg::CMD_RESET;
          next_erasing = 1'b0;
          next_op_done = 1'b1;
          next_st = S_IDLE;
        end else if (wcnt == CNT_ZERO_L) next_st = S_POLL; // RL17
      end
      S_POLL: if (!bc_busy) begin
        if (CMD_VALID && CMD_OP == flash_host_pkg::OP_RESET) begin
          next_rst_pin = 1'b0; // RL11 RL17
          next_dly = 16'(flash_host_pkg::T_PULSE_CYC * 10);
          next_st = S_RST;
        end else if (CMD_VALID && CMD_OP == flash_host_pkg::OP_SUSPEND &&
            !chip && !susp) begin
          bc_start = 1'b1; // RL17 RL18
          bc_word.data[7:0] = flash_host_pkg::CMD_SUSPEND;
          next_dly = 16'(ERASE_SUSP_CYC); // RL19
          next_st = S_WAIT;
        end else begin
          bc_start = 1'b1;
          bc_write = 1'b0;
          bc_word.addr = chip ? '0 : sa;
          next_st = S_WAIT;
          next_dly = CNT_ONE_L;
        end
      end
      S_WAIT: if (bc_done) begin
        next_stat.data_poll_bit = bc_rdata[flash_host_pkg::DATA_POLL];
        next_stat.toggle_bit = bc_rdata[flash_host_pkg::TOGGLE];
        next_stat.erase_timer_bit = bc_rdata[flash_host_pkg::ERASE_TIMER];
        next_stat.alternate_toggle_bit = bc_rdata[flash_host_pkg::ALT_TOGGLE];
        if (dly > CNT_ONE_L) begin
          next_st = S_SUSP;
        end else if (erasing && bc_rdata[flash_host_pkg::DATA_POLL] &&
            bc_rdata[flash_host_pkg::TOGGLE] ==
            stat.toggle_bit) begin
          // toggle stopped: erase finished, back to array read
          next_erasing = 1'b0; // RL10
          next_op_done = 1'b1;
          next_st = S_IDLE;
        end else if (!erasing) begin
          next_susp = 1'b1;
          next_op_done = 1'b1;
          next_st = S_IDLE;
        end else next_st = S_POLL; // RL9
      end
      S_SUSP: if (dly <= CNT_ONE_L) begin
        next_susp = 1'b1; // RL20
        next_op_done = 1'b1;
        next_st = S_IDLE;
      end else next_dly = dly - 16'h0001;
      S_RST: begin
        next_rst_pin = (dly <= CNT_ONE_L);
        if (dly <= CNT_ONE_L) begin
          next_erasing = 1'b0;
          next_susp = 1'b0;
          next_op_done = 1'b1;
          next_st = S_IDLE;
        end else next_dly = dly - 16'h0001;
      end
    endcase
    // suspend in window: erasing state held, suspension recorded later
    if (st == S_WAIT && bc_done && dly == CNT_ONE_L && susp == 1'b0 &&
        erasing && !chip && last == 3'h5 && next_st == S_SUSP)
      next_susp = 1'b1;
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      st <= S_IDLE;
      idx <= 3'h0;
      last <= 3'h5;
      chip <= 1'b0;
      erasing <= 1'b0;
      susp <= 1'b0;
      late <= 1'b0;
      op_done <= 1'b0;
      rst_pin <= 1'b1;
      sa <= '0;
      wcnt <= '0;
      dly <= '0;
      stat <= '0;
    end else begin
      st <= next_st;
      idx <= next_idx;
      last <= next_last;
      chip <= next_chip;
      erasing <= next_erasing;
      susp <= next_susp;
      late <= next_late;
      op_done <= next_op_done;
      rst_pin <= next_rst_pin;
      sa <= next_sa;
      wcnt <= next_wcnt;
      dly <= next_dly;
      stat <= next_stat;
    end
  end

  // program is the device's other path; no ID/query issued here
  // program-side rules stay with the device: RL1 RL3 RL5 RL6 RL21
  assign READY = (st == S_IDLE) ||
    ((st == S_WINDOW || st == S_POLL) && !bc_busy); // RL4
  assign OP_DONE = op_done;
  assign ERASING = erasing;
  assign SUSPENDED = susp;
  assign WINDOW_LATE = late;
  assign STATUS = stat;
  assign FLASH_RESET_B = rst_pin;
endmodule

// ==== dv/flash_erase_host_props.sv ====
/*
  Checker for flash_erase_host: write strobe shape, command cycle
  addresses, suspend latency, done pulse. Sees only the top's ports.
*/
`timescale 1ns/1ps
module flash_erase_host_props #(
  parameter int WINDOW_CYC = 300,
  parameter int ERASE_SUSP_CYC = 200,
  parameter int PROG_SUSP_CYC = 150
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // status
  input wire logic OP_DONE,
  input wire logic ERASING,
  input wire logic SUSPENDED,
  // flash pins
  input wire logic [flash_host_pkg::AW-1:0] FLASH_ADDR,
  input wire logic [flash_host_pkg::DW-1:0] FLASH_DQ_OUT,
  input wire logic FLASH_DQ_OE,
  input wire logic FLASH_CE_B,
  input wire logic FLASH_WE_B,
  input wire logic FLASH_OE_B,
  input wire logic FLASH_RESET_B
);
  // host counts out the latency after the write cycle before it flags suspend
  localparam int SUSP_MAX = ERASE_SUSP_CYC + 300;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  AST_WE_PULSE: assert property (
    $fell(FLASH_WE_B) |=> !FLASH_WE_B [*3] ##1 FLASH_WE_B)
    else $error("write strobe width wrong");
  AST_WE_CE: assert property (!FLASH_WE_B |-> !FLASH_CE_B)
    else $error("write strobe without chip select");
  AST_NO_CONTENTION: assert property (FLASH_DQ_OE |-> FLASH_OE_B)
    else $error("host drives data during a read");
  AST_WRITE_STABLE: assert property (
    !FLASH_WE_B && !$past(FLASH_WE_B) |->
      $stable(FLASH_ADDR) && $stable(FLASH_DQ_OUT))
    else $error("address or data moved under write strobe");
  AST_DONE_PULSE: assert property (OP_DONE |=> !OP_DONE)
    else $error("done longer than one cycle");
  AST_SUSP_ERASING: assert property (SUSPENDED |-> ERASING)
    else $error("suspended without erase");
  AST_RESET_PIN: assert property (
    $fell(FLASH_RESET_B) |-> !FLASH_RESET_B [*8])
    else $error("flash reset pulse too short");
  AST_SUSP_LAT: assert property (
    $rose(FLASH_WE_B) && FLASH_DQ_OUT[7:0] == flash_host_pkg::CMD_SUSPEND
      && ERASING && !SUSPENDED |-> ##[1:SUSP_MAX] SUSPENDED)
    else $error("suspend not reported in time");
  AST_SETUP_ADDR: assert property (
    $rose(FLASH_WE_B) && FLASH_DQ_OUT[7:0] == flash_host_pkg::CMD_ERASE_SETUP
      |-> FLASH_ADDR[10:0] == flash_host_pkg::ADDR_UNLOCK1)
    else $error("erase set-up at wrong address");
  AST_UNLOCK2_ADDR: assert property (
    $rose(FLASH_WE_B) && FLASH_DQ_OUT[7:0] == flash_host_pkg::CMD_UNLOCK2
      |-> FLASH_ADDR[10:0] == flash_host_pkg::ADDR_UNLOCK2)
    else $error("second unlock at wrong address");
endmodule
bind flash_erase_host flash_erase_host_props #(
  .WINDOW_CYC(WINDOW_CYC), .ERASE_SUSP_CYC(ERASE_SUSP_CYC),
  .PROG_SUSP_CYC(PROG_SUSP_CYC)
) props (
  .CLOCK(CLOCK), .RST_B(RST_B), .OP_DONE(OP_DONE), .ERASING(ERASING),
  .SUSPENDED(SUSPENDED), .FLASH_ADDR(FLASH_ADDR),
  .FLASH_DQ_OUT(FLASH_DQ_OUT), .FLASH_DQ_OE(FLASH_DQ_OE),
  .FLASH_CE_B(FLASH_CE_B), .FLASH_WE_B(FLASH_WE_B),
  .FLASH_OE_B(FLASH_OE_B), .FLASH_RESET_B(FLASH_RESET_B)
);

// ==== dv/flash_dev_model.sv ====
/*
  Behavioural NOR flash for the erase host: unlock and erase decode,
  sector window, erase suspend/resume, status reads.
  Assumes host strobes move just after clk edges; the bench sets the
  erase length and suspend latency.
*/
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int WIN = 300
) (
  // clock and knobs
  input wire logic clk,
  input var int erase_len,
  input var int susp_lat,
  // pins
  input wire logic [21:0] addr,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  output logic [15:0] dq_in,
  input wire logic ce_b,
  input wire logic we_b,
  input wire logic oe_b,
  input wire logic reset_b,
  // observation
  output logic [2:0] state,
  output int nsec
);
  localparam logic [2:0] RD = 3'h0, WNDW = 3'h1, ERS = 3'h2;
  localparam logic [2:0] SUS = 3'h3, CHIP = 3'h4;
  logic we_q, oe_q, tog, wr;
  logic [15:0] rd, last;
  logic [7:0] cmd;
  logic [10:0] lo;
  int seq, tmr, sl;
  assign wr = we_b && !we_q && !ce_b && dq_oe;
  assign cmd = dq_out[7:0];
  assign lo = addr[10:0];
  // busy reads give status; toggles flip once per read, but bit 6 is held high in suspend
  assign rd = (state == RD) ? 16'hffff : {8'h00, state == SUS,
    (state == SUS) | tog, 2'b00, state != WNDW, tog, 2'b00};
  // released bus shows the inverse, never a stale value
  assign dq_in = (!oe_b && !ce_b) ? rd : ~last;
  always @(posedge clk or negedge reset_b) begin
    if (!reset_b) begin
      state <= RD;
      seq <= 0;
      tmr <= 0;
      sl <= 0;
      nsec <= 0;
      we_q <= 1'b1;
      oe_q <= 1'b1;
      tog <= 1'b0;
      last <= 16'h0000;
    end else begin
      we_q <= we_b;
      oe_q <= oe_b;
      if (!oe_b && !ce_b) last <= rd;
      if (oe_b && !oe_q && state != RD) tog <= ~tog;
      if (state != RD && state != SUS && tmr > 0) tmr <= tmr - 1;
      if (sl > 0) sl <= sl - 1;
      if (sl == 1) state <= SUS;
      if (tmr == 1 && state == WNDW) begin
        state <= ERS;
        tmr <= erase_len;
      end
      if (tmr == 1 && (state == ERS || state == CHIP)) begin
        state <= RD;
        sl <= 0;
      end
      if (wr) begin
        case (state)
          RD: begin
            seq <= 0;
            if (seq < 5 && lo == (seq % 3 == 1 ? 11'h2aa : 11'h555) &&
                cmd == (seq == 2 ? 8'h80 : (seq % 3 == 1 ? 8'h55 : 8'haa)))
              seq <= seq + 1;
            if (seq == 5 && cmd == 8'h10 && lo == 11'h555) begin
              state <= CHIP;
              tmr <= 2 * erase_len;
            end
            if (seq == 5 && cmd == 8'h30) begin
              state <= WNDW;
              tmr <= WIN;
              nsec <= 1;
            end
          end
          WNDW: if (cmd == 8'h30) begin
            tmr <= WIN;
            nsec <= nsec + 1;
          end else if (cmd == 8'hb0) begin
            state <= SUS;
            tmr <= erase_len;
          end else state <= RD;
          ERS: if (cmd == 8'hb0 && sl == 0) sl <= susp_lat;
          SUS: if (cmd == 8'h30) state <= ERS;
          default: ;
        endcase
      end
    end
  end
endmodule

// ==== dv/flash_erase_host_tb_top.sv ====
/*
  Self-checking bench for flash_erase_host against a flash model:
  chip erase, queued sectors, suspend/resume, aborts by reset.
  Assumes the design package and the flash model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  fails++; $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module flash_erase_host_tb_top;
  logic clock, rst_b, cmd_valid, ready, op_done, erasing, suspended;
  logic window_late, dq_oe, ce_b, we_b, oe_b, fl_reset_b;
  flash_host_pkg::op_t cmd_op;
  flash_host_pkg::flash_status_t status;
  logic [21:0] cmd_addr, fl_addr;
  logic [15:0] dq_out, dq_in, rnd;
  logic [2:0] fm_state;
  int fm_nsec, erase_len, susp_lat, fails, compares, i, j, nx;
  flash_erase_host #(.WINDOW_CYC(300), .ERASE_SUSP_CYC(200),
    .PROG_SUSP_CYC(150)) dut (.CLOCK(clock), .RST_B(rst_b),
    .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr),
    .READY(ready), .OP_DONE(op_done), .ERASING(erasing),
    .SUSPENDED(suspended), .WINDOW_LATE(window_late), .STATUS(status),
    .FLASH_ADDR(fl_addr), .FLASH_DQ_OUT(dq_out), .FLASH_DQ_OE(dq_oe),
    .FLASH_DQ_IN(dq_in), .FLASH_CE_B(ce_b), .FLASH_WE_B(we_b),
    .FLASH_OE_B(oe_b), .FLASH_RESET_B(fl_reset_b));
  flash_dev_model #(.WIN(300)) fm (.clk(clock), .erase_len(erase_len),
    .susp_lat(susp_lat), .addr(fl_addr), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in), .ce_b(ce_b), .we_b(we_b), .oe_b(oe_b),
    .reset_b(fl_reset_b && rst_b), .state(fm_state), .nsec(fm_nsec));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // 0 erasing, 1 suspended, 10 and up: flash state equals w - 10
  function automatic logic sig(input int w);
    if (w >= 10) return fm_state == 3'(w - 10);
    return (w == 0) ? erasing : suspended;
  endfunction
  task automatic finish_test();
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic issue(input flash_host_pkg::op_t op, input logic [21:0] a);
    int n;
    n = 0;
    @(posedge clock);
    #1;
    cmd_op = op;
    cmd_addr = a;
    cmd_valid = 1'b1;
    while (!ready && n < 20000) begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    `CHK("order taken", 1'b1, n < 20000)
  endtask
  task automatic wait_sig(input int w, input logic v);
    int n;
    n = 0;
    while (sig(w) !== v && n < 20000) begin
      @(posedge clock);
      #1;
      n++;
    end
    `CHK("wait result", v, sig(w))
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #1000000;
    fails++;
    finish_test();
  end
  initial begin
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = flash_host_pkg::OP_RESET;
    cmd_addr = 22'h000000;
    fails = 0;
    compares = 0;
    rnd = 16'h4100;
    erase_len = 600;
    susp_lat = 40;
    repeat (4) @(posedge clock);
    #1 rst_b = 1'b1;
    // suspend must not take hold during a whole-chip erase
    issue(flash_host_pkg::OP_CHIP_ERASE, 22'h000000);
    wait_sig(14, 1'b1);
    issue(flash_host_pkg::OP_SUSPEND, 22'h000000);
    `CHK("chip no suspend", 1'b0, fm_state == 3'h3)
    wait_sig(0, 1'b0);
    `CHK("after chip", 3'h0, fm_state)
    for (i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      erase_len = 600 + int'(rnd[8:0]);
      susp_lat = 20 + int'(rnd[6:0]);
      nx = int'(rnd[10:9]);
      issue(flash_host_pkg::OP_SECTOR_ERASE, {rnd[6:0], 15'h0000});
      for (j = 1; j <= nx; j++)
        issue(flash_host_pkg::OP_ADD_SECTOR, {rnd[6:0] ^ 7'(j), 15'h0000});
      if (i == 0) begin
        // suspend inside the window ends it at once
        issue(flash_host_pkg::OP_SUSPEND, 22'h000000);
        wait_sig(13, 1'b1);
        wait_sig(1, 1'b1);
        issue(flash_host_pkg::OP_SUSPEND, 22'h000000);
        `CHK("second suspend", 3'h3, fm_state)
        issue(flash_host_pkg::OP_RESUME, 22'h000000);
        wait_sig(12, 1'b1);
        issue(flash_host_pkg::OP_RESUME, 22'h000000);
        `CHK("second resume", 1'b0, fm_state == 3'h3)
      end
      wait_sig(12, 1'b1);
      `CHK("sectors", nx + 1, fm_nsec)
      issue(flash_host_pkg::OP_SUSPEND, 22'h000000);
      wait_sig(1, 1'b1);
      `CHK("suspended", 3'h3, fm_state)
      issue(flash_host_pkg::OP_RESUME, 22'h000000);
      wait_sig(0, 1'b0);
      `CHK("erase end", 3'h0, fm_state)
    end
    `CHK("late add", 1'b0, window_late)
    // another order inside the window abandons the erase
    issue(flash_host_pkg::OP_SECTOR_ERASE, 22'h008000);
    issue(flash_host_pkg::OP_RESET, 22'h000000);
    wait_sig(10, 1'b1);
    `CHK("window abort", 3'h0, fm_state)
    // hardware reset cuts a chip erase short
    issue(flash_host_pkg::OP_CHIP_ERASE, 22'h000000);
    wait_sig(14, 1'b1);
    issue(flash_host_pkg::OP_RESET, 22'h000000);
    wait_sig(10, 1'b1);
    wait_sig(0, 1'b0);
    `CHK("reset abort", 3'h0, fm_state)
    finish_test();
  end
endmodule
